//--- logic/nfsc_map.vh
// constants for the flash status and signature host controller
`ifndef NFSC_MAP_VH
`define NFSC_MAP_VH
// =====================================================
// apb register offsets (byte addresses)
`define NFSC_REG_CTRL      12'h000
`define NFSC_REG_CMD       12'h004
`define NFSC_REG_STATUS    12'h008
`define NFSC_REG_SIG       12'h00C
`define NFSC_REG_GEOM      12'h010
`define NFSC_REG_IRQ_STAT  12'h014
`define NFSC_REG_IRQ_MASK  12'h018
// =====================================================
// control register fields
`define NFSC_CTRL_WP_EN    0
`define NFSC_CTRL_CACHE    1
// command codes written to the cmd register
`define NFSC_OP_STATUS     2'h1
`define NFSC_OP_SIG        2'h2
// =====================================================
// flash command and address codes
`define NFSC_FL_STATUS     8'h70
`define NFSC_FL_SIG        8'h90
`define NFSC_FL_SIG_ADDR   8'h00
`define NFSC_SIG_ITEMS     3'h4
// =====================================================
// status word bit positions
`define NFSC_SB_UNPROT     7
`define NFSC_SB_ENG_CACHE  6
`define NFSC_SB_IDLE       5
`define NFSC_SB_PRIOR_FAIL 1
`define NFSC_SB_OP_FAIL    0
`define NFSC_SB_USED_MASK  8'hE3
// =====================================================
// interrupt status bits
`define NFSC_IRQ_DONE      0
`define NFSC_IRQ_FAIL      1
`define NFSC_IRQ_PROT      2
// =====================================================
// strobe timing: a phase of at least 50 ns at 20 ns clock
`define NFSC_PHASE_NS      50
`define NFSC_CLK_NS        20
`define NFSC_PHASE_CYC     ((`NFSC_PHASE_NS + `NFSC_CLK_NS - 1) / `NFSC_CLK_NS)
`endif

//--- logic/nfsc_sync.v
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module nfsc_sync #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_q;  // first stage, read only by second
  reg [W-1:0] s2_q;  // second stage, safe to use
  // =====================================================
  // double registration
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end
  assign q = s2_q;
endmodule // nfsc_sync

//--- logic/nfsc_strobe.v
// strobe phase timer: counts a fixed number of cycles after start
`timescale 1ns/10ps
`include "nfsc_map.vh"
module nfsc_strobe (
  input  wire clk,
  input  wire rst_n,
  input  wire start,
  output wire done
);
  reg [3:0] cnt_q;  // cycles left in the phase
  reg [3:0] cnt_d;
  // phase length in clocks; small enough for the four-bit counter
  localparam integer PHASE_CYC = `NFSC_PHASE_CYC;
  // =====================================================
  // down counter, done pulses when it reaches one
  always @* begin
    cnt_d = cnt_q;
    if (start) begin
      cnt_d = PHASE_CYC[3:0];
    end else if (cnt_q != 4'h0) begin
      cnt_d = cnt_q - 4'h1;
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  assign done = (cnt_q == 4'h1);
endmodule // nfsc_strobe

//--- logic/nfsc_host.v
// host controller: status read, signature read and write-protect pin
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/10ps
`include "nfsc_map.vh"
// Overview of operation
// - host ignores bit 1 outside cache
// - bits 4..2 reserved, host ignores them
// - signature: command 90h then address 00h
// - hold write protect low at power
module nfsc_host (
  input  wire        clk,
  input  wire        rst_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output wire        irq,
  // flash pins
  output reg         fl_ce_n,
  output reg         fl_cle,
  output reg         fl_ale,
  output reg         fl_we_n,
  output reg         fl_re_n,
  output reg         fl_wp_n,
  output reg  [7:0]  fl_io_out,
  output reg         fl_io_oe,
  input  wire [7:0]  fl_io_in
);
  // =====================================================
  // states; codes 6 and 7 are unused and fall back to idle
  localparam SQ_IDLE = 3'h0;  // chip deselected
  localparam SQ_CMD  = 3'h1;  // command byte on the bus
  localparam SQ_ADDR = 3'h2;  // address byte on the bus
  localparam SQ_RDLO = 3'h3;  // read strobe low half
  localparam SQ_RDHI = 3'h4;  // read strobe high half
  localparam SQ_GAP  = 3'h5;  // deselect gap before done
  reg  [2:0]  seq_q;       // sequencer state
  reg  [1:0]  op_q;        // running operation
  reg  [2:0]  idx_q;       // signature item index
  reg         phase_q;     // 0: strobe low half, 1: strobe high half
  reg  [1:0]  ctrl_q;      // control register
  reg  [7:0]  status_q;    // last status word read
  reg  [31:0] sig_q;       // four signature items, first in low byte
  reg  [2:0]  irq_stat_q;  // sticky events
  reg  [2:0]  irq_mask_q;  // event mask
  reg         in_status_q; // device left in status mode
  reg  [2:0]  ev_set;      // events raised this cycle
  wire [7:0]  io_s;        // synchronised data lines
  wire        ph_done;     // strobe phase elapsed
  reg         ph_start;    // start a strobe phase
  wire        busy;
  wire        wr;
  wire        rd;
  // =====================================================
  // read data pins via two flops before use
  nfsc_sync #(.W(8)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (fl_io_in),
    .q     (io_s)
  );
  // one timer serves every strobe half, so all halves share one length
  nfsc_strobe u_strobe (
    .clk   (clk),
    .rst_n (rst_n),
    .start (ph_start),
    .done  (ph_done)
  );
  // =====================================================
  // apb decode: zero wait state
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign busy    = (seq_q != SQ_IDLE);
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & penable & ~pwrite;
  assign irq     = |(irq_stat_q & irq_mask_q);

  // decode a status word into its reported fields; reserved bits dropped
  function [7:0] clean_status;
    input [7:0] s;
    begin
      clean_status = s & `NFSC_SB_USED_MASK;
    end
  endfunction

  // read mux
  always @* begin
    prdata = 32'h0000_0000;
    case (paddr)
      `NFSC_REG_CTRL:     prdata = {30'h0, ctrl_q};
      `NFSC_REG_CMD:      prdata = {31'h0, busy};
      // outside cache programming bit 1 carries nothing, show zero
      `NFSC_REG_STATUS:   prdata = {24'h0, clean_status(status_q) &
                                    (ctrl_q[`NFSC_CTRL_CACHE] ? 8'hFF : 8'hFD)};
      `NFSC_REG_SIG:      prdata = sig_q;
      // geometry fields unpacked: page, spare, block, org, access
      // bits 12:11 access time, 6 org, 5:4 block, 2 spare, 1:0 page
      `NFSC_REG_GEOM:     prdata = {19'h0, sig_q[31], sig_q[27], 4'h0, sig_q[30],
                                    sig_q[29:28], 1'b0, sig_q[26], sig_q[25:24]};
      `NFSC_REG_IRQ_STAT: prdata = {29'h0, irq_stat_q};
      `NFSC_REG_IRQ_MASK: prdata = {29'h0, irq_mask_q};
      default:            prdata = 32'h0000_0000;
    endcase
  end
  // =====================================================
  // software registers and sticky interrupts; set beats read-clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q     <= 2'h0;
      irq_mask_q <= 3'h0;
      irq_stat_q <= 3'h0;
    end else begin
      if (wr && paddr == `NFSC_REG_CTRL) begin
        ctrl_q <= pwdata[1:0];
      end
      if (wr && paddr == `NFSC_REG_IRQ_MASK) begin
        irq_mask_q <= pwdata[2:0];
      end
      // a read clears the word, but an event of this very cycle survives
      if (rd && paddr == `NFSC_REG_IRQ_STAT) begin
        irq_stat_q <= ev_set;
      end else begin
        irq_stat_q <= irq_stat_q | ev_set;
      end
    end
  end
  // =====================================================
  // write protect pin: low protects; held low from reset until enabled
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fl_wp_n <= 1'b0;
    end else begin
      // only an explicit enable from software lifts the protection
      fl_wp_n <= ctrl_q[`NFSC_CTRL_WP_EN];
    end
  end
  // =====================================================
  // pin sequencer: each strobe half lasts one phase
  // a cmd write while busy is dropped, so software polls busy first
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_q       <= SQ_IDLE;
      op_q        <= 2'h0;
      idx_q       <= 3'h0;
      phase_q     <= 1'b0;
      status_q    <= 8'h00;
      sig_q       <= 32'h0000_0000;
      in_status_q <= 1'b0;
      fl_ce_n     <= 1'b1;
      fl_cle      <= 1'b0;
      fl_ale      <= 1'b0;
      fl_we_n     <= 1'b1;
      fl_re_n     <= 1'b1;
      fl_io_out   <= 8'h00;
      fl_io_oe    <= 1'b0;
      ev_set      <= 3'h0;
      ph_start    <= 1'b0;
    end else begin
      ev_set   <= 3'h0;
      ph_start <= 1'b0;
      case (seq_q)
        // chip deselected; wait for an order from software
        SQ_IDLE: begin
          fl_ce_n <= 1'b1;
          if (wr && paddr == `NFSC_REG_CMD &&
              (pwdata[1:0] == `NFSC_OP_STATUS || pwdata[1:0] == `NFSC_OP_SIG)) begin
            op_q     <= pwdata[1:0];
            idx_q    <= 3'h0;
            phase_q  <= 1'b0;
            fl_ce_n  <= 1'b0;
            ph_start <= 1'b1;
            // device stays in status mode, so repeat reads skip the command
            if (pwdata[1:0] == `NFSC_OP_STATUS && in_status_q) begin
              seq_q   <= SQ_RDLO;
              fl_re_n <= 1'b0;
            end else begin
              seq_q     <= SQ_CMD;
              fl_cle    <= 1'b1;
              fl_we_n   <= 1'b0;
              fl_io_oe  <= 1'b1;
              fl_io_out <= (pwdata[1:0] == `NFSC_OP_SIG) ? `NFSC_FL_SIG
                                                           : `NFSC_FL_STATUS;
            end
          end
        end
        // command byte: write strobe low half, then high half
        SQ_CMD: begin
          if (ph_done) begin
            ph_start <= 1'b1;
            if (!phase_q) begin
              // rising write strobe latches the byte in the device
              fl_we_n <= 1'b1;
              phase_q <= 1'b1;
            end else begin
              // hold time over: drop the latch enable and move on
              phase_q     <= 1'b0;
              fl_cle      <= 1'b0;
              in_status_q <= (op_q == `NFSC_OP_STATUS);
              if (op_q == `NFSC_OP_SIG) begin
                seq_q     <= SQ_ADDR;
                fl_ale    <= 1'b1;
                fl_we_n   <= 1'b0;
                fl_io_out <= `NFSC_FL_SIG_ADDR;
              end else begin
                seq_q    <= SQ_RDLO;
                fl_io_oe <= 1'b0;
                fl_re_n  <= 1'b0;
              end
            end
          end
        end
        // address byte, same shape as the command byte
        SQ_ADDR: begin
          if (ph_done) begin
            ph_start <= 1'b1;
            if (!phase_q) begin
              // rising write strobe latches the address
              fl_we_n <= 1'b1;
              phase_q <= 1'b1;
            end else begin
              // bus released in the same cycle as the first read strobe falls
              phase_q  <= 1'b0;
              fl_ale   <= 1'b0;
              fl_io_oe <= 1'b0;
              fl_re_n  <= 1'b0;
              seq_q    <= SQ_RDLO;
            end
          end
        end
        SQ_RDLO: begin
          // data valid late in the low phase; sample synced copy there
          if (ph_done) begin
            ph_start <= 1'b1;
            fl_re_n  <= 1'b1;
            seq_q    <= SQ_RDHI;
            if (op_q == `NFSC_OP_STATUS) begin
              status_q <= io_s;
            end else begin
              sig_q <= {io_s, sig_q[31:8]};
              idx_q <= idx_q + 3'h1;
            end
          end
        end
        // read strobe high half; more items or finish
        SQ_RDHI: begin
          if (ph_done) begin
            // another signature item still outstanding
            if (op_q == `NFSC_OP_SIG && idx_q != `NFSC_SIG_ITEMS) begin
              ph_start <= 1'b1;
              fl_re_n  <= 1'b0;
              seq_q    <= SQ_RDLO;
            end else begin
              seq_q   <= SQ_GAP;
              fl_ce_n <= 1'b1;
            end
          end
        end
        // one cycle deselected, then report done and judge the word
        SQ_GAP: begin
          seq_q <= SQ_IDLE;
          ev_set[`NFSC_IRQ_DONE] <= 1'b1;
          if (op_q == `NFSC_OP_STATUS) begin
            // bit 0 current page fail; bit 1 prior page only when caching
            ev_set[`NFSC_IRQ_FAIL] <= status_q[`NFSC_SB_OP_FAIL] |
              (ctrl_q[`NFSC_CTRL_CACHE] & status_q[`NFSC_SB_PRIOR_FAIL]);
            ev_set[`NFSC_IRQ_PROT] <= ~status_q[`NFSC_SB_UNPROT];
          end else begin
            in_status_q <= 1'b0;
          end
        end
        // unused codes fall back to idle
        default: begin
          seq_q <= SQ_IDLE;
        end
      endcase
    end
  end
  // =====================================================
  // status bit handling
  // bits 6 and 5 (cache ready / engine idle) are passed through raw
  // in the status register for software to interpret by mode;
  // the sequencer does not wait on them, so a busy device is only
  // reported, and software polls it with repeated status orders
endmodule // nfsc_host

//--- testbench/nfsc_host_sva.sv
// checker for the flash host controller pins and apb side
`timescale 1ns/10ps
module nfsc_host_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        fl_ce_n,
  input wire logic        fl_cle,
  input wire logic        fl_ale,
  input wire logic        fl_we_n,
  input wire logic        fl_re_n,
  input wire logic        fl_wp_n,
  input wire logic [7:0]  fl_io_out,
  input wire logic        fl_io_oe
);
  // =====================================================
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_apb_no_wait: assert property (psel && penable |-> pready)
    else $error("apb access not answered at once");
  a_apb_no_error: assert property (psel && penable |-> !pslverr)
    else $error("apb access flagged as error");
  a_cmd_code_out: assert property (fl_cle && !fl_we_n |-> fl_io_oe &&
    (fl_io_out == 8'h70 || fl_io_out == 8'h90)) else $error("bad command byte");
  a_addr_zero_out: assert property (fl_ale && !fl_we_n |-> fl_io_oe &&
    fl_io_out == 8'h00) else $error("bad address byte");
  a_sig_addr_follows: assert property ($rose(fl_we_n) && fl_cle &&
    $past(fl_io_out) == 8'h90 |-> ##[1:12] fl_ale) else $error("no address after 90h");
  a_latch_exclusive: assert property (!(fl_cle && fl_ale))
    else $error("command and address latch together");
  a_read_bus_free: assert property (!fl_re_n |-> !fl_io_oe && !fl_ce_n)
    else $error("read strobe with bus driven or chip idle");
  a_we_pulse_width: assert property ($fell(fl_we_n) |-> !fl_we_n [*4] ##1 fl_we_n)
    else $error("write strobe width wrong");
  a_re_pulse_width: assert property ($fell(fl_re_n) |-> !fl_re_n [*4] ##1 fl_re_n)
    else $error("read strobe width wrong");
  a_wp_release_sw: assert property ($rose(fl_wp_n) |->
    $past(psel, 2) && $past(penable, 2) && $past(pwrite, 2) &&
    $past(paddr, 2) == 12'h000 && $past(pwdata[0], 2))
    else $error("write protect released without order");
  a_wp_assert_sw: assert property ($fell(fl_wp_n) |->
    $past(psel, 2) && $past(penable, 2) && $past(pwrite, 2) &&
    $past(paddr, 2) == 12'h000 && !$past(pwdata[0], 2))
    else $error("write protect asserted without order");
endmodule // nfsc_host_chk
bind nfsc_host nfsc_host_chk u_chk (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .fl_ce_n, .fl_cle, .fl_ale, .fl_we_n, .fl_re_n, .fl_wp_n,
  .fl_io_out, .fl_io_oe);

//--- testbench/nfsc_flash_model.sv
// behavioural flash device: status word and signature readout
`timescale 1ns/10ps
module nfsc_flash_model #(
  parameter logic [7:0] MAKER = 8'h3C, // arbitrary value
  parameter logic [7:0] DEVID = 8'h7E, // arbitrary value
  parameter logic [7:0] CAPAB = 8'h80,
  parameter logic [7:0] GEOM  = 8'h5D  // 2k page, 16 spare, 128k block, x16, 30ns
) (
  input  wire logic       ce_n,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       re_n,
  input  wire logic       wp_n,
  input  wire logic [7:0] din,
  input  wire logic       eng_idle,
  input  wire logic       cache_op,
  input  wire logic       cache_rdy,
  input  wire logic       fail_cur,
  input  wire logic       fail_prev,
  output wire logic [7:0] dout
);
  logic [7:0] cmd_q  = 8'h00; // last command accepted
  logic       addr_q = 1'b0;  // address 00h seen after 90h
  logic [1:0] idx_q  = 2'h0;  // signature item index
  logic [7:0] last_q = 8'h00; // last byte driven
  logic [7:0] data;
  wire        drive = !ce_n && !re_n;
  // live status, rebuilt on every read; reserved bits deliberately 1
  wire [7:0] stat = {wp_n, cache_op ? cache_rdy : eng_idle, eng_idle,
    3'b111, fail_prev, fail_cur};
  always @* begin
    case (idx_q)
      2'h0: data = MAKER;
      2'h1: data = DEVID;
      2'h2: data = CAPAB;
      default: data = GEOM;
    endcase
    if (cmd_q == 8'h70) data = stat;
    else if (cmd_q != 8'h90 || !addr_q) data = ~last_q;
  end
  // released bus shows the inverse so a stale byte never passes
  assign dout = drive ? data : ~last_q;
  // command and address latch on the rising write strobe
  always @(posedge we_n) begin
    if (!ce_n && cle) begin
      cmd_q <= din;
      addr_q <= 1'b0;
      idx_q <= 2'h0;
    end else if (!ce_n && ale) begin
      addr_q <= (din == 8'h00);
    end
  end
  always @(posedge re_n) begin
    idx_q <= idx_q + 2'h1;
  end
  always @(negedge re_n) begin
    #1 last_q <= data;
  end
endmodule // nfsc_flash_model

//--- testbench/test_flash_status_and_signature.sv
// self-checking bench for the flash host controller
`timescale 1ns/10ps
`include "nfsc_map.vh"
module test_flash_status_and_signature;
  logic        clk = 1'b0, rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, irq, ce_n, cle, ale, we_n, re_n, wp_n, oe;
  logic [7:0]  io_out, io_in;
  logic        idle = 1'b1, cop = 1'b0, crdy = 1'b0, fc = 1'b0, fp = 1'b0;
  int          mismatches = 0, total_checks = 0, cyc = 0;
  always #10 clk = ~clk;
  nfsc_host dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(), .irq(irq), .fl_ce_n(ce_n), .fl_cle(cle), .fl_ale(ale), .fl_we_n(we_n),
    .fl_re_n(re_n), .fl_wp_n(wp_n), .fl_io_out(io_out), .fl_io_oe(oe), .fl_io_in(io_in));
  nfsc_flash_model u_dev (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
    .wp_n(wp_n), .din(io_out), .eng_idle(idle), .cache_op(cop), .cache_rdy(crdy),
    .fail_cur(fc), .fail_prev(fp), .dout(io_in));
  task end_sim;
    if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard, well above the two hundred or so cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer: setup, access until pready, then release
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // start an operation and poll busy until it clears
  task run_op(input logic [1:0] op);
    apb(1'b1, `NFSC_REG_CMD, {30'h0, op});
    do apb(1'b0, `NFSC_REG_CMD, 32'h0); while (rd[0] !== 1'b0);
  endtask
  task s_reset_regs;
    rd_chk(`NFSC_REG_CTRL, 32'h0);
    rd_chk(`NFSC_REG_IRQ_STAT, 32'h0);
    rd_chk(12'h01C, 32'h0);
    chk({31'h0, wp_n}, 32'h0);
  endtask
  task s_status_plain;
    apb(1'b1, `NFSC_REG_CTRL, 32'h1);
    fp <= 1'b1;
    run_op(`NFSC_OP_STATUS);
    rd_chk(`NFSC_REG_STATUS, 32'hE0);
    chk({31'h0, irq}, 32'h0);
    rd_chk(`NFSC_REG_IRQ_STAT, 32'h1);
    rd_chk(`NFSC_REG_IRQ_STAT, 32'h0);
  endtask
  task s_status_prot;
    apb(1'b1, `NFSC_REG_IRQ_MASK, 32'h7);
    apb(1'b1, `NFSC_REG_CTRL, 32'h0);
    idle <= 1'b0;
    fc <= 1'b1;
    run_op(`NFSC_OP_STATUS);
    rd_chk(`NFSC_REG_STATUS, 32'h01);
    chk({31'h0, irq}, 32'h1);
    rd_chk(`NFSC_REG_IRQ_STAT, 32'h7);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
  endtask
  task s_status_cache;
    apb(1'b1, `NFSC_REG_CTRL, 32'h3);
    cop <= 1'b1;
    crdy <= 1'b1;
    fc <= 1'b0;
    run_op(`NFSC_OP_STATUS);
    rd_chk(`NFSC_REG_STATUS, 32'hC2);
    rd_chk(`NFSC_REG_IRQ_STAT, 32'h3);
  endtask
  task s_signature;
    apb(1'b1, `NFSC_REG_CTRL, 32'h1);
    run_op(`NFSC_OP_SIG);
    rd_chk(`NFSC_REG_SIG, 32'h5D807E3C);
    rd_chk(`NFSC_REG_GEOM, 32'h855);
    cop <= 1'b0;
    idle <= 1'b1;
    fp <= 1'b0;
    run_op(`NFSC_OP_STATUS);
    rd_chk(`NFSC_REG_STATUS, 32'hE0);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    s_reset_regs();
    s_status_plain();
    s_status_prot();
    s_status_cache();
    s_signature();
    end_sim();
  end
endmodule // test_flash_status_and_signature
